//--- design/ulsu_line_status.v
// Upper line-status logic of one UART channel with its APB register slave.
// Assumes receiver and transmitter logic on sys_clk; rxLine is an asynchronous pin.
//
// Function
// R01: Bit 7 high while any stored receive character has a parity, framing or break tag.
// R02: Bit 7 clears only when no remaining stored character carries an error tag.
// R03: Non-FIFO mode: bit 6 high when holding and shift registers are both empty.
// R04: FIFO mode: bit 6 high when transmit FIFO and shift register are both empty.
// R05: Non-FIFO mode: bit 5 sets when the holding character moves into the shift register.
// R06: Non-FIFO mode: bit 5 clears at the CPU write into the holding register.
// R07: FIFO mode: bit 5 sets when transmit FIFO empties, clears on any write.
// R08: Transmit interrupt request while bit 5 set and transmit interrupt enabled.
// R09: Bit 4 set when the receive line stays low for one whole frame time.
// R10: Only one break character is stored per break, however long the line stays low.
// R11: Bit 3 set when a received character lacks a valid stop bit.
// R12: FIFO mode: framing flag shows the head character; each entry keeps its own tags.
// R13: After reset break, framing and FIFO error flags read zero.
// R14: Bit 2 flags bad parity; in FIFO mode it belongs to the head character.
// R15: CPU writes to the line status register are ignored.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ulsu_defines.vh"

module ulsu_line_status
(
   // Clock and reset
   input  wire         sys_clk,
   input  wire         resetn,
   // APB slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata_reg,
   output reg          pready_reg,
   output reg          pslverr_reg,
   // Serial receive pin
   input  wire         rxLine,
   // Receiver character strobe
   input  wire         rxCharValid,
   input  wire [7:0]   rxCharData,
   input  wire         rxParityErr,
   input  wire         rxFramingErr,
   // Transmitter handshake
   input  wire         txShiftLoad,
   input  wire         txShiftEmpty,
   output reg          txPush_reg,
   output reg  [7:0]   txPushData_reg,
   // Status and interrupt
   output reg  [7:0]   lineStatus_reg,
   output reg          txIrq_reg
);

   // ******************************
   // Reset and pin synchronisers
   // ******************************
   reg        rstMeta_reg;
   reg        rstSyncN_reg;
   reg        rxMeta_reg;
   reg        rxSync_reg;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rstMeta_reg  <= 1'b0;
         rstSyncN_reg <= 1'b0;
      end
      else
      begin
         rstMeta_reg  <= 1'b1;
         rstSyncN_reg <= rstMeta_reg;
      end
   end

   // Idle line is high, so the reset value avoids a false break
   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
      end
      else
      begin
         rxMeta_reg <= rxLine;
         rxSync_reg <= rxMeta_reg;
      end
   end

   // ******************************
   // APB decode
   // ******************************
   reg  [1:0]  ctrl_reg;
   reg  [15:0] frameCyc_reg;
   wire        fifoMode   = ctrl_reg[`ULSU_CTRL_FIFO_EN];
   wire        accessDone = psel & penable & pready_reg;
   wire        setupPhase = psel & ~penable;
   wire        hitRx      = (paddr == `ULSU_OFS_RX_DATA);
   wire        hitTx      = (paddr == `ULSU_OFS_TX_DATA);
   wire        hitLs      = (paddr == `ULSU_OFS_LINE_STATUS);
   wire        hitCtrl    = (paddr == `ULSU_OFS_CTRL);
   wire        hitFrame   = (paddr == `ULSU_OFS_FRAME_CYC);
   wire        mapped     = hitRx | hitTx | hitLs | hitCtrl | hitFrame;
   wire        cpuTxWrite = accessDone & pwrite & hitTx;
   wire        cpuRxPop   = accessDone & ~pwrite & hitRx;

   // ******************************
   // Break detection
   // ******************************
   reg  [15:0] lowCnt_reg;
   reg         breakArmed_reg;
   wire        breakEvent = ~rxSync_reg & breakArmed_reg & (lowCnt_reg >= frameCyc_reg);

   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         lowCnt_reg     <= 16'h0000;
         breakArmed_reg <= 1'b1;
      end
      else if (rxSync_reg)
      begin
         lowCnt_reg     <= 16'h0000;
         breakArmed_reg <= 1'b1;
      end
      else
      begin
         if (lowCnt_reg != 16'hFFFF)
         begin
            lowCnt_reg <= lowCnt_reg + 16'h0001;
         end
         // Disarm until the line returns high: one break entry per break
         if (breakEvent)
         begin
            breakArmed_reg <= 1'b0; // R10
         end
      end
   end

   // ******************************
   // Receive FIFO with error tags
   // ******************************
   reg  [`ULSU_PTR_W-1:0] wrPtr_reg;
   reg  [`ULSU_PTR_W-1:0] rdPtr_reg;
   reg  [`ULSU_CNT_W-1:0] rxCnt_reg;
   reg  [`ULSU_CNT_W-1:0] errCnt_reg;
   reg                    overrun_reg;
   wire [`ULSU_ENT_W-1:0] headEntry;
   wire [`ULSU_CNT_W-1:0] rxLimit = fifoMode ? `ULSU_LIMIT_FIFO : `ULSU_LIMIT_ONE;
   wire                   rxEmpty = (rxCnt_reg == 0);
   wire                   rxFull  = (rxCnt_reg >= rxLimit);
   wire                   pushReq = rxCharValid | breakEvent;
   // A break also fails the stop bit, so it carries the framing tag too
   wire [`ULSU_ENT_W-1:0] pushEntry = breakEvent ? 11'h600 :
                                      {1'b0, rxFramingErr, rxParityErr, rxCharData}; // R11 R14
   wire                   pushTagged = |pushEntry[`ULSU_ENT_BI:`ULSU_ENT_PE];
   wire                   popOk    = cpuRxPop & ~rxEmpty;
   wire                   pushOk   = pushReq & (~rxFull | popOk);
   wire                   headTagged = |headEntry[`ULSU_ENT_BI:`ULSU_ENT_PE];
   wire                   popTagged  = popOk & headTagged;
   // Read one ahead on a pop so the head tags never lag a cycle
   wire [`ULSU_PTR_W-1:0] rdAddrNext = popOk ? rdPtr_reg + 1'b1 : rdPtr_reg;

   ulsu_rx_fifo_mem u_rxMem
   (
      .clk        (sys_clk),
      .wrEn       (pushOk),
      .wrAddr     (wrPtr_reg),
      .wrData     (pushEntry),
      .rdAddr     (rdAddrNext),
      .rdData_reg (headEntry)
   );

   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         wrPtr_reg   <= {`ULSU_PTR_W{1'b0}};
         rdPtr_reg   <= {`ULSU_PTR_W{1'b0}};
         rxCnt_reg   <= {`ULSU_CNT_W{1'b0}};
         errCnt_reg  <= {`ULSU_CNT_W{1'b0}}; // R13
         overrun_reg <= 1'b0;
      end
      else
      begin
         if (pushOk)
         begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (popOk)
         begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (pushOk & ~popOk)
         begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
         end
         else if (popOk & ~pushOk)
         begin
            rxCnt_reg <= rxCnt_reg - 1'b1;
         end
         // Count of tagged entries still stored
         if ((pushOk & pushTagged) & ~popTagged)
         begin
            errCnt_reg <= errCnt_reg + 1'b1; // R01
         end
         else if (popTagged & ~(pushOk & pushTagged))
         begin
            errCnt_reg <= errCnt_reg - 1'b1; // R02
         end
         // Overrun: incoming character dropped; a new one wins over the read clear
         if (pushReq & ~pushOk)
         begin
            overrun_reg <= 1'b1;
         end
         else if (accessDone & ~pwrite & hitLs)
         begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // ******************************
   // Transmit holding / FIFO occupancy
   // ******************************
   reg  [`ULSU_CNT_W-1:0] txCnt_reg;
   wire [`ULSU_CNT_W-1:0] txLimit  = fifoMode ? `ULSU_LIMIT_FIFO : `ULSU_LIMIT_ONE;
   wire                   txAccept = cpuTxWrite & (txCnt_reg < txLimit);
   wire                   txTake   = txShiftLoad & (txCnt_reg != 0);
   reg  [`ULSU_CNT_W-1:0] txCnt_next;

   always @*
   begin
      txCnt_next = txCnt_reg;
      if (txAccept & ~txTake)
      begin
         txCnt_next = txCnt_reg + 1'b1;
      end
      else if (txTake & ~txAccept)
      begin
         txCnt_next = txCnt_reg - 1'b1;
      end
   end

   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         txCnt_reg      <= {`ULSU_CNT_W{1'b0}};
         txPush_reg     <= 1'b0;
         txPushData_reg <= 8'h00;
      end
      else
      begin
         txCnt_reg  <= txCnt_next;
         txPush_reg <= txAccept;
         if (txAccept)
         begin
            txPushData_reg <= pwdata[7:0];
         end
      end
   end

   // ******************************
   // Line status and interrupt
   // ******************************
   reg  [7:0] lineStatus_next;
   wire       headValid = ~rxEmpty;
   wire       thrEmptyNext = (txCnt_next == 0);

   always @*
   begin
      lineStatus_next = 8'h00;
      lineStatus_next[`ULSU_LS_DATA_READY] = headValid;
      lineStatus_next[`ULSU_LS_OVERRUN]    = overrun_reg;
      // Tags of the head entry only
      lineStatus_next[`ULSU_LS_PARITY]  = headValid & headEntry[`ULSU_ENT_PE]; // R14
      lineStatus_next[`ULSU_LS_FRAMING] = headValid & headEntry[`ULSU_ENT_FE]; // R11 R12
      lineStatus_next[`ULSU_LS_BREAK]   = headValid & headEntry[`ULSU_ENT_BI]; // R09
      // Set when the last held character leaves, cleared by the write itself
      lineStatus_next[`ULSU_LS_THR_EMPTY] = thrEmptyNext; // R05 R06 R07
      lineStatus_next[`ULSU_LS_TX_EMPTY]  = thrEmptyNext & txShiftEmpty; // R03 R04
      lineStatus_next[`ULSU_LS_FIFO_ERR]  = (errCnt_reg != 0); // R01 R02
   end

   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         lineStatus_reg <= `ULSU_LS_RESET; // R13
         txIrq_reg      <= 1'b0;
      end
      else
      begin
         lineStatus_reg <= lineStatus_next;
         txIrq_reg      <= lineStatus_next[`ULSU_LS_THR_EMPTY] &
                           ctrl_reg[`ULSU_CTRL_TX_IEN]; // R08
      end
   end

   // ******************************
   // APB slave: no wait state, registered answer
   // ******************************
   reg [31:0] rdMux;

   always @*
   begin
      rdMux = 32'h00000000;
      if (hitRx)
      begin
         rdMux = {24'h000000, headValid ? headEntry[7:0] : 8'h00};
      end
      else if (hitLs)
      begin
         rdMux = {24'h000000, lineStatus_reg};
      end
      else if (hitCtrl)
      begin
         rdMux = {30'h00000000, ctrl_reg};
      end
      else if (hitFrame)
      begin
         rdMux = {16'h0000, frameCyc_reg};
      end
   end

   always @(posedge sys_clk or negedge rstSyncN_reg)
   begin
      if (!rstSyncN_reg)
      begin
         prdata_reg   <= 32'h00000000;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
         ctrl_reg     <= `ULSU_CTRL_RESET;
         frameCyc_reg <= `ULSU_FRAME_CYC_RESET;
      end
      else
      begin
         if (setupPhase)
         begin
            pready_reg  <= 1'b1;
            pslverr_reg <= ~mapped;
            prdata_reg  <= pwrite ? 32'h00000000 : rdMux;
         end
         else if (accessDone)
         begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
         end
         // Status register has no write path at all
         if (accessDone & pwrite & hitCtrl)
         begin
            ctrl_reg <= pwdata[1:0];
         end
         if (accessDone & pwrite & hitFrame)
         begin
            frameCyc_reg <= pwdata[15:0];
         end
      end
   end // R15

endmodule // ulsu_line_status

`default_nettype wire

//--- include/ulsu_defines.vh
// Constants of the upper line-status logic: register map, fields, resets, sizes.
// Included by the design files; holds definitions only.
`ifndef ULSU_DEFINES_VH
`define ULSU_DEFINES_VH

// ******************************
// Register byte offsets (APB)
// ******************************
`define ULSU_OFS_RX_DATA      8'h00
`define ULSU_OFS_TX_DATA      8'h04
`define ULSU_OFS_LINE_STATUS  8'h08
`define ULSU_OFS_CTRL         8'h0C
`define ULSU_OFS_FRAME_CYC    8'h10

// ******************************
// Line status bit positions
// ******************************
`define ULSU_LS_DATA_READY    0
`define ULSU_LS_OVERRUN       1
`define ULSU_LS_PARITY        2
`define ULSU_LS_FRAMING       3
`define ULSU_LS_BREAK         4
`define ULSU_LS_THR_EMPTY     5
`define ULSU_LS_TX_EMPTY      6
`define ULSU_LS_FIFO_ERR      7

// ******************************
// Control bit positions and resets
// ******************************
`define ULSU_CTRL_FIFO_EN     0
`define ULSU_CTRL_TX_IEN      1
`define ULSU_CTRL_RESET       2'h0
`define ULSU_FRAME_CYC_RESET  16'h1B20

// ******************************
// Receive entry layout and FIFO sizes
// ******************************
`define ULSU_ENT_PE           8
`define ULSU_ENT_FE           9
`define ULSU_ENT_BI           10
`define ULSU_ENT_W            11
`define ULSU_FIFO_DEPTH       16
`define ULSU_PTR_W            4
`define ULSU_CNT_W            5
`define ULSU_LIMIT_FIFO       5'h10
`define ULSU_LIMIT_ONE        5'h01
`define ULSU_LS_RESET         8'h60

`endif

//--- design/ulsu_rx_fifo_mem.v
// Receive FIFO storage: 16 entries of data plus error tags.
// Assumes one clock; read data is registered, so it trails the address by one edge.
`timescale 1ns/1ps
`default_nettype none
`include "ulsu_defines.vh"

module ulsu_rx_fifo_mem
(
   // Clock
   input  wire                     clk,
   // Write port
   input  wire                     wrEn,
   input  wire [`ULSU_PTR_W-1:0]   wrAddr,
   input  wire [`ULSU_ENT_W-1:0]   wrData,
   // Read port
   input  wire [`ULSU_PTR_W-1:0]   rdAddr,
   output reg  [`ULSU_ENT_W-1:0]   rdData_reg
);

   reg [`ULSU_ENT_W-1:0] mem [0:`ULSU_FIFO_DEPTH-1];

   always @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      // Write-first, so a push into an empty FIFO shows at once
      rdData_reg <= (wrEn && (wrAddr == rdAddr)) ? wrData : mem[rdAddr];
   end

endmodule // ulsu_rx_fifo_mem

`default_nettype wire

//--- dv/ulsu_tx_partner.sv
// Transmitter model: takes pushed characters into a shift register.
// Assumes one clock; stall holds back loads so the holding side stays full.
`timescale 1ns/1ps
`default_nettype none

module ulsu_tx_partner
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Control and handshake
   input  wire logic stall,
   input  wire logic push,
   output var  logic load,
   output var  logic shiftEmpty
);
   logic [4:0] pend;
   logic [4:0] busy;

   // Load only when something is held, so no load is ever ignored
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pend <= 5'h00;
         busy <= 5'h00;
         load <= 1'b0;
      end
      else
      begin
         load <= (pend != 5'h00) && (busy == 5'h00) && !stall && !load;
         pend <= pend + {4'h0, push} - {4'h0, load};
         busy <= load ? 5'h10 : ((busy != 5'h00) ? busy - 5'h01 : 5'h00);
      end
   end

   assign shiftEmpty = (busy == 5'h00) && !load;
endmodule // ulsu_tx_partner

`default_nettype wire

//--- dv/ulsu_line_status_asserts.sv
// Checker of the line-status block, seeing only its top ports.
// Assumes one clock domain; bound from the bench file.
`timescale 1ns/1ps
`default_nettype none

module ulsu_line_status_asserts
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready_reg,
   input wire logic        pslverr_reg,
   // Receive and transmit
   input wire logic        rxLine,
   input wire logic        rxCharValid,
   input wire logic        rxParityErr,
   input wire logic        rxFramingErr,
   input wire logic        txShiftEmpty,
   input wire logic        txPush_reg,
   input wire logic [7:0]  lineStatus_reg,
   input wire logic        txIrq_reg
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence tx_write;
      psel && penable && pwrite && pready_reg && (paddr == 8'h04);
   endsequence

   chk_reset_flags: assert property ($rose(resetn) |-> lineStatus_reg == 8'h60)
      else $error("status not idle after reset");
   chk_ready_once: assert property (apb_setup |=> pready_reg ##1 !pready_reg)
      else $error("ready not one cycle after setup");
   chk_err_ready: assert property (pslverr_reg |-> pready_reg)
      else $error("slave error without ready");
   chk_push_cause: assert property (txPush_reg |-> $past(psel && penable && pwrite && pready_reg && (paddr == 8'h04)))
      else $error("push without data write");
   chk_write_clears: assert property (tx_write |=> !lineStatus_reg[5])
      else $error("holding empty still set after write");
   chk_irq_needs: assert property (txIrq_reg |-> lineStatus_reg[5])
      else $error("irq without holding empty");
   chk_shift_busy: assert property (!$past(txShiftEmpty) |-> !lineStatus_reg[6])
      else $error("all empty while shift busy");
   chk_empty_pair: assert property (lineStatus_reg[6] |-> lineStatus_reg[5])
      else $error("all empty without holding empty");
   chk_err_sets: assert property (rxCharValid && (rxParityErr || rxFramingErr)
      && !lineStatus_reg[0] |-> ##2 lineStatus_reg[7])
      else $error("fifo error not set");
   chk_parity_err: assert property ($rose(lineStatus_reg[2]) |-> lineStatus_reg[7])
      else $error("parity flag without fifo error");
   chk_break_low: assert property ($rose(lineStatus_reg[4]) |-> !$past(rxLine, 8))
      else $error("break flag with line high");
endmodule // ulsu_line_status_asserts

`default_nettype wire

//--- dv/ulsu_line_status_bench.sv
// Self-checking bench of the line-status block over APB.
// Assumes the design defines header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ulsu_defines.vh"

module ulsu_line_status_bench;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        rxLine = 1'b1;
   logic        rxCharValid = 1'b0;
   logic [7:0]  rxCharData = 8'h00;
   logic        rxParityErr = 1'b0;
   logic        rxFramingErr = 1'b0;
   logic        txShiftLoad;
   logic        txShiftEmpty;
   logic        txPush_reg;
   logic [7:0]  txPushData_reg;
   logic [7:0]  lineStatus_reg;
   logic        txIrq_reg;
   logic        stall = 1'b1;
   logic [31:0] rdat;
   logic        rerr;
   int          num_errors = 0;
   int          compares = 0;

   always #5 sys_clk = ~sys_clk;

   ulsu_line_status dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg),
      .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .rxLine(rxLine),
      .rxCharValid(rxCharValid), .rxCharData(rxCharData), .rxParityErr(rxParityErr),
      .rxFramingErr(rxFramingErr), .txShiftLoad(txShiftLoad), .txShiftEmpty(txShiftEmpty),
      .txPush_reg(txPush_reg), .txPushData_reg(txPushData_reg),
      .lineStatus_reg(lineStatus_reg), .txIrq_reg(txIrq_reg));

   ulsu_tx_partner tx (.clk(sys_clk), .rstn(resetn), .stall(stall), .push(txPush_reg),
      .load(txShiftLoad), .shiftEmpty(txShiftEmpty));

   task conclude;
      if (num_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready_reg !== 1'b1);
      rdat = prdata_reg;
      rerr = pslverr_reg;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   task rxp(input logic [7:0] d, input logic pe, input logic fe);
      @(posedge sys_clk);
      rxCharValid <= 1'b1;
      rxCharData <= d;
      rxParityErr <= pe;
      rxFramingErr <= fe;
      @(posedge sys_clk);
      rxCharValid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      rdc(`ULSU_OFS_CTRL, 32'h0);
      rdc(`ULSU_OFS_FRAME_CYC, 32'h1B20);
      apb(1'b1, `ULSU_OFS_LINE_STATUS, 32'hFF);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      rdc(8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      // Non-FIFO transmit with the shifter stalled
      apb(1'b1, `ULSU_OFS_CTRL, 32'h2);
      apb(1'b1, `ULSU_OFS_TX_DATA, 32'h5A);
      @(posedge sys_clk);
      chk({31'h0, txPush_reg}, 32'h1);
      chk({24'h0, txPushData_reg}, 32'h5A);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h00);
      chk({31'h0, txIrq_reg}, 32'h0);
      stall <= 1'b0;
      while (txShiftLoad !== 1'b1) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h20);
      chk({31'h0, txIrq_reg}, 32'h1);
      repeat (20) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      // Receive errors, non-FIFO then FIFO
      rxp(8'h33, 1'b1, 1'b0);
      rdc(`ULSU_OFS_LINE_STATUS, 32'hE5);
      rdc(`ULSU_OFS_RX_DATA, 32'h33);
      repeat (4) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      rxp(8'h44, 1'b0, 1'b0);
      rxp(8'h55, 1'b0, 1'b0);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h63);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h61);
      rdc(`ULSU_OFS_RX_DATA, 32'h44);
      apb(1'b1, `ULSU_OFS_CTRL, 32'h3);
      rxp(8'h11, 1'b0, 1'b0);
      rxp(8'h22, 1'b0, 1'b1);
      rdc(`ULSU_OFS_LINE_STATUS, 32'hE1);
      rdc(`ULSU_OFS_RX_DATA, 32'h11);
      repeat (4) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'hE9);
      rdc(`ULSU_OFS_RX_DATA, 32'h22);
      repeat (4) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      // FIFO transmit, two bytes queued
      stall <= 1'b1;
      apb(1'b1, `ULSU_OFS_TX_DATA, 32'hA1);
      apb(1'b1, `ULSU_OFS_TX_DATA, 32'hA2);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h00);
      stall <= 1'b0;
      repeat (60) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      // Long break gives one entry only
      apb(1'b1, `ULSU_OFS_FRAME_CYC, 32'h14);
      rxLine <= 1'b0;
      repeat (100) @(posedge sys_clk);
      rxLine <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'hF9);
      rdc(`ULSU_OFS_RX_DATA, 32'h0);
      repeat (4) @(posedge sys_clk);
      rdc(`ULSU_OFS_LINE_STATUS, 32'h60);
      conclude();
   end
endmodule // ulsu_line_status_bench

bind ulsu_line_status ulsu_line_status_asserts chk_i (.sys_clk(sys_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready_reg(pready_reg),
   .pslverr_reg(pslverr_reg), .rxLine(rxLine), .rxCharValid(rxCharValid),
   .rxParityErr(rxParityErr), .rxFramingErr(rxFramingErr), .txShiftEmpty(txShiftEmpty),
   .txPush_reg(txPush_reg), .lineStatus_reg(lineStatus_reg), .txIrq_reg(txIrq_reg));

`default_nettype wire
